// [include/rt_msg_defines.svh]
// constants for the terminal message buffer and mode code block
`ifndef RT_MSG_DEFINES_SVH
`define RT_MSG_DEFINES_SVH

// --------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_LAST_CMD    8'h08
`define OFS_BIT_WORD    8'h18
`define OFS_TIMER       8'h1C
`define OFS_SRQ         8'h24
`define OFS_VECTOR      8'h28
`define OFS_MIW_LAST    8'h2C
`define OFS_STATE       8'h30
`define OFS_LEGAL_BASE  8'h40
`define LEGAL_REG_CNT   16

// --------------------------------------------------------------
// control and service request register fields
// --------------------------------------------------------------
`define CTRL_INDEXED    0
`define CTRL_ENHANCED   1
`define CTRL_DBA_EN     2
`define CTRL_OVR_EN     3
`define SRQ_BIT         8

// --------------------------------------------------------------
// message information word fields
// --------------------------------------------------------------
`define MIW_CODE_HI     15
`define MIW_CODE_LO     11
`define MIW_BUS_A       9
`define MIW_T2T         8
`define MIW_FAULT       7
`define MIW_BCAST       5
`define MIW_ILLEGAL     4
`define MIW_SHORT       3
`define MIW_EXCESS      2
`define MIW_PARITY      1
`define MIW_LINECODE    0

// --------------------------------------------------------------
// command word, status word and mode codes
// --------------------------------------------------------------
`define CMD_TR          10
`define SA_MODE_LO      5'h00
`define SA_MODE_HI      5'h1F
`define MAX_WORDS       6'h20
`define MC_DYN_BUS      5'h00
`define MC_SYNC         5'h01
`define MC_TX_STATUS    5'h02
`define MC_SHUTDOWN     5'h04
`define MC_OVR_SHUT     5'h05
`define MC_INH_TF       5'h06
`define MC_OVR_INH_TF   5'h07
`define MC_RESET_RT     5'h08
`define MC_VECTOR       5'h10
`define MC_SYNC_DATA    5'h11
`define MC_LAST_CMD     5'h12
`define MC_BIT_WORD     5'h13
`define MC_DATA_BIT     4
`define ST_ERROR        10
`define ST_SRQ          8
`define ST_BCAST        4
`define ST_DBA          1
`define ST_TFLAG        0

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define CLK_MHZ         20
`define TICK_US         1
`define TICK_CYCLES     (`CLK_MHZ * `TICK_US)

`endif

// [include/rt_msg_pkg.sv]
// types shared by the terminal message buffer block
package rt_msg_pkg;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_RX   = 7'h02,
    S_WR   = 7'h04,
    S_RD   = 7'h08,
    S_MIW  = 7'h10,
    S_TT   = 7'h20,
    S_POST = 7'h40
  } seq_state_t;
endpackage

// [rtl/rt_msg_buffer.sv]
// terminal message buffering, message information word and mode code handling
// Operation
// - buffer holds info word, then time tag, then up to 32 data words
// - every data pointer addresses the info word, not first data word
// - info word 15:11 carries word count or mode code; bits 10, 6 zero
// - bit 9 marks bus A; bit 8 marks terminal-to-terminal receive
// - bit 7 marks any error; bits 4:0 give the cause
// - bit 5 marks broadcast in enhanced mode
// - bit 4 illegal command; bit 2 too many or unexpected words
// - receive: bit 3 too few words; bit 1 parity; bit 0 line code
// - time tag holds timer value when command is validated
// - every mode code stores its command word, except transmit-last-command
// - each mode code legal or illegal through legalization registers 16 to 31
// - sync with data loads timer; sync without data clears it
// - dynamic bus control sets acceptance bit when control enables it
// - transmit status sends held status; status updated even if illegal
// - shutdown disables other bus; override gated by control; reset clears
// - inhibit code blocks terminal flag; override code re-enables it
// - vector word code transmits a word and clears service request
// - built-in-test code transmits register 6 contents
// - indexed: advance pointer after receive, decrement depth, irq on 1 to 0
// - indexed transmit reads start two past the data pointer
// - irq needs enable bit; depth decrements only on clean legal messages
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`include "rt_msg_defines.svh"

module rt_msg_buffer
  import rt_msg_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // ahb-lite register slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // decoded words from the bus protocol logic
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  input  wire logic        cmd_bus_a,
  input  wire logic        cmd_bcast,
  input  wire logic        cmd_t2t,
  input  wire logic        data_valid,
  input  wire logic [15:0] data_word,
  input  wire logic        data_parity_err,
  input  wire logic        data_code_err,
  input  wire logic        msg_end,
  input  wire logic        tx_req,
  input  wire logic        tf_request,
  // descriptor fields read by the descriptor logic
  input  wire logic [15:0] desc_ptr,
  input  wire logic [7:0]  desc_depth,
  input  wire logic        desc_irq_en,
  // shared memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  // transmit side
  output logic             tx_valid,
  output logic [15:0]      tx_word,
  output logic [15:0]      status_word,
  output logic [1:0]       bus_disable,
  output logic             core_reset,
  // descriptor update
  output logic             desc_upd,
  output logic [15:0]      desc_new_ptr,
  output logic [7:0]       desc_new_depth,
  output logic             depth_zero_irq
);

  // --------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [15:0] ctrl_q, bit_q, srq_q, vector_q, last_cmd_q, miw_q;
  logic [15:0] legal_q [`LEGAL_REG_CNT];
  logic [15:0] timer_q;
  logic [4:0]  tick_q;
  logic        tf_inhibit_q, dba_q;

  wire addr_phase = hsel & htrans[1] & hready;
  wire wr_hit     = wr_pend_q;
  wire legal_sel  = (haddr >= `OFS_LEGAL_BASE);
  wire [3:0] legal_idx = haddr[5:2];
  wire [3:0] wr_legal_idx = wr_addr_q[5:2];
  wire [15:0] state_view = {12'h000, tf_inhibit_q, bus_disable, dba_q};
  wire [15:0] rd_mux =
    legal_sel                   ? legal_q[legal_idx] :
    (haddr == `OFS_CTRL)        ? ctrl_q :
    (haddr == `OFS_LAST_CMD)    ? last_cmd_q :
    (haddr == `OFS_BIT_WORD)    ? bit_q :
    (haddr == `OFS_TIMER)       ? timer_q :
    (haddr == `OFS_SRQ)         ? srq_q :
    (haddr == `OFS_VECTOR)      ? vector_q :
    (haddr == `OFS_MIW_LAST)    ? miw_q :
    (haddr == `OFS_STATE)       ? state_view : 16'h0000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_q <= haddr;
        hrdata    <= {16'h0000, rd_mux};
      end
    end
  end

  // --------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------
  wire        is_tx    = cmd_word[`CMD_TR];
  wire [4:0]  sa       = cmd_word[9:5];
  wire [4:0]  code     = cmd_word[4:0];
  wire        is_mode  = (sa == `SA_MODE_LO) || (sa == `SA_MODE_HI);
  wire [7:0]  leg_bit  = {cmd_bcast, is_tx, is_mode, code};
  wire        illegal  = legal_q[leg_bit[7:4]][leg_bit[3:0]];
  wire        mc_go    = cmd_valid & is_mode & ~illegal;
  wire        tx_mc    = mc_go & is_tx;
  wire        last_mc  = is_mode & is_tx & (code == `MC_LAST_CMD);
  wire [5:0]  expect_n = is_mode ? ((~is_tx & code[`MC_DATA_BIT]) ? 6'h01 : 6'h00) :
                         is_tx   ? 6'h00 :
                         (code == 5'h00) ? `MAX_WORDS : {1'b0, code};
  wire        tx_data_mc = is_mode & is_tx & code[`MC_DATA_BIT];

  // --------------------------------------------------------------
  // software registers and mode code side effects
  // --------------------------------------------------------------
  logic [15:0] status_q;
  logic sync_load;
  logic [15:0] sync_val;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q       <= 16'h0000;
      bit_q        <= 16'h0000;
      srq_q        <= 16'h0000;
      vector_q     <= 16'h0000;
      last_cmd_q   <= 16'h0000;
      tf_inhibit_q <= 1'b0;
      dba_q        <= 1'b0;
      bus_disable  <= 2'b00;
      core_reset   <= 1'b0;
      for (int i = 0; i < `LEGAL_REG_CNT; i++) legal_q[i] <= 16'h0000;
    end else begin
      core_reset <= 1'b0;
      if (wr_hit) begin
        if (wr_addr_q >= `OFS_LEGAL_BASE) legal_q[wr_legal_idx] <= hwdata[15:0];
        if (wr_addr_q == `OFS_CTRL)     ctrl_q   <= hwdata[15:0];
        if (wr_addr_q == `OFS_BIT_WORD) bit_q    <= hwdata[15:0];
        if (wr_addr_q == `OFS_SRQ)      srq_q    <= hwdata[15:0];
        if (wr_addr_q == `OFS_VECTOR)   vector_q <= hwdata[15:0];
      end
      if (cmd_valid & is_mode & ~last_mc) last_cmd_q <= cmd_word;
      if (tx_mc) begin
        if (code == `MC_DYN_BUS) dba_q <= ctrl_q[`CTRL_DBA_EN];
        if (code == `MC_SHUTDOWN) bus_disable <= cmd_bus_a ? 2'b10 : 2'b01;
        if (code == `MC_OVR_SHUT && ctrl_q[`CTRL_OVR_EN]) bus_disable <= 2'b00;
        if (code == `MC_RESET_RT) begin
          bus_disable <= 2'b00;
          core_reset  <= 1'b1;
        end
        if (code == `MC_INH_TF)     tf_inhibit_q <= 1'b1;
        if (code == `MC_OVR_INH_TF) tf_inhibit_q <= 1'b0;
        if (code == `MC_VECTOR)     srq_q[`SRQ_BIT] <= 1'b0;
      end
      if (cmd_valid && !(is_mode && is_tx && code == `MC_DYN_BUS)) dba_q <= 1'b0;
    end
  end

  // held status; transmit-status keeps the previous word on the wire
  // the inhibit code already clears the flag in its own reply
  wire tf_block = (tf_inhibit_q | (tx_mc & (code == `MC_INH_TF))) &
                  ~(tx_mc & (code == `MC_OVR_INH_TF));
  wire [15:0] status_next = {5'h00, 1'b0 | illegal, 1'b0, srq_q[`SRQ_BIT], 3'b000,
                             cmd_bcast, 2'b00, 1'b0, tf_request & ~tf_block};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 16'h0000;
    end else if (cmd_valid) begin
      status_q <= status_next;
    end
  end
  // an illegal transmit-status request reports the error instead of the held word
  wire hold_status = mc_go & is_tx & (code == `MC_TX_STATUS);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_word <= 16'h0000;
    end else if (cmd_valid) begin
      status_word <= hold_status ? status_q :
                     {status_next[15:2], dba_q | (tx_mc & code == `MC_DYN_BUS &
                      ctrl_q[`CTRL_DBA_EN]), status_next[0]};
    end
  end

  // --------------------------------------------------------------
  // time tag timer, one tick per microsecond
  // --------------------------------------------------------------
  wire tick = (tick_q == 5'(`TICK_CYCLES - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q  <= 5'h00;
      timer_q <= 16'h0000;
    end else begin
      tick_q <= tick ? 5'h00 : tick_q + 5'h01;
      if (tx_mc && code == `MC_SYNC) timer_q <= 16'h0000;
      else if (sync_load) timer_q <= sync_val;
      else if (tick) timer_q <= timer_q + 16'h0001;
    end
  end

  // --------------------------------------------------------------
  // message sequencer
  // --------------------------------------------------------------
  seq_state_t  st_q;
  logic [15:0] ptr_q, tag_q, wbuf_q;
  logic [5:0]  cnt_q, expect_q;
  logic [15:0] code_q;
  logic        tx_q, mode_q, bcast_q, bus_a_q, t2t_q, ill_q, skip_q;
  logic        excess_q, parity_q, lcode_q, mc_data_q, sync_q;
  logic [7:0]  depth_q;
  logic        irq_en_q;

  wire [15:0] data_base = ptr_q + 16'h0002;
  wire [15:0] word_addr = data_base + {10'h000, cnt_q};
  wire        short_f   = ~tx_q & (cnt_q < expect_q);
  wire [4:0]  cause     = {ill_q, short_f, excess_q, parity_q & ~tx_q, lcode_q & ~tx_q};
  wire        fault     = |cause;
  wire [15:0] miw_val   = {code_q[4:0], 1'b0, bus_a_q, t2t_q & ~tx_q, fault, 1'b0,
                           bcast_q & ctrl_q[`CTRL_ENHANCED], cause};
  wire        indexed   = ctrl_q[`CTRL_INDEXED];
  wire        clean     = ~fault;
  wire [15:0] mc_word   = (code_q[4:0] == `MC_LAST_CMD) ? last_cmd_q :
                          (code_q[4:0] == `MC_BIT_WORD) ? bit_q :
                          vector_q;

  assign sync_load = sync_q & data_valid & (st_q == S_RX);
  assign sync_val  = data_word;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      {ptr_q, tag_q, wbuf_q, code_q} <= 64'h0;
      {cnt_q, expect_q} <= 12'h000;
      {tx_q, mode_q, bcast_q, bus_a_q, t2t_q, ill_q, skip_q} <= 7'h00;
      {excess_q, parity_q, lcode_q, mc_data_q, sync_q} <= 5'h00;
      depth_q <= 8'h00;
      irq_en_q <= 1'b0;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          if (cmd_valid) begin
            st_q      <= S_RX;
            ptr_q     <= desc_ptr;
            depth_q   <= desc_depth;
            irq_en_q  <= desc_irq_en;
            tag_q     <= timer_q;
            code_q    <= cmd_word;
            tx_q      <= is_tx;
            mode_q    <= is_mode;
            bcast_q   <= cmd_bcast;
            bus_a_q   <= cmd_bus_a;
            t2t_q     <= cmd_t2t;
            ill_q     <= illegal;
            skip_q    <= last_mc & illegal;
            cnt_q     <= 6'h00;
            expect_q  <= expect_n;
            mc_data_q <= tx_data_mc;
            sync_q    <= mc_go & ~is_tx & (code == `MC_SYNC_DATA);
            {excess_q, parity_q, lcode_q} <= 3'b000;
          end
        end
        S_RX: begin
          if (data_valid) begin
            parity_q <= parity_q | data_parity_err;
            lcode_q  <= lcode_q | data_code_err;
            if (tx_q || cnt_q >= expect_q) begin
              excess_q <= 1'b1;
            end else begin
              wbuf_q <= data_word;
              st_q   <= S_WR;
            end
          end else if (tx_req && tx_q) begin
            st_q <= mode_q ? S_RX : S_RD;
          end else if (msg_end) begin
            st_q <= skip_q ? S_IDLE : S_MIW;
          end
        end
        S_WR: begin
          if (data_valid) excess_q <= 1'b1;
          if (mem_ack) begin
            cnt_q <= cnt_q + 6'h01;
            st_q  <= S_RX;
          end
        end
        S_RD: begin
          if (mem_ack) begin
            cnt_q <= cnt_q + 6'h01;
            st_q  <= S_RX;
          end
        end
        S_MIW: if (mem_ack) st_q <= S_TT;
        S_TT:  if (mem_ack) st_q <= S_POST;
        S_POST: st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // memory port, transmit word and descriptor update
  // --------------------------------------------------------------
  wire        go_mem = (st_q == S_WR) | (st_q == S_RD) | (st_q == S_MIW) | (st_q == S_TT);
  wire [15:0] addr_d = (st_q == S_MIW) ? ptr_q :
                       (st_q == S_TT)  ? ptr_q + 16'h0001 :
                       word_addr;
  wire [15:0] wdat_d = (st_q == S_MIW) ? miw_val :
                       (st_q == S_TT)  ? tag_q : wbuf_q;
  wire        upd_now = (st_q == S_POST);
  wire        rx_upd  = upd_now & indexed & ~tx_q & clean;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= 1'b0;
      mem_we  <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      tx_valid <= 1'b0;
      tx_word <= 16'h0000;
      miw_q <= 16'h0000;
      desc_upd <= 1'b0;
      desc_new_ptr <= 16'h0000;
      desc_new_depth <= 8'h00;
      depth_zero_irq <= 1'b0;
    end else begin
      mem_req   <= go_mem & ~mem_ack;
      mem_we    <= (st_q != S_RD);
      mem_addr  <= addr_d;
      mem_wdata <= wdat_d;
      tx_valid  <= ((st_q == S_RD) & mem_ack) | ((st_q == S_RX) & tx_req & tx_q & mode_q &
                   mc_data_q & ~ill_q);
      if (st_q == S_RD && mem_ack) tx_word <= mem_rdata;
      else if (st_q == S_RX && tx_req && mode_q) tx_word <= mc_word;
      if (st_q == S_MIW && mem_ack) miw_q <= miw_val;
      desc_upd <= upd_now;
      desc_new_ptr <= rx_upd ? data_base + {10'h000, cnt_q} : ptr_q;
      desc_new_depth <= (rx_upd && depth_q != 8'h00) ? depth_q - 8'h01 : depth_q;
      depth_zero_irq <= rx_upd & (depth_q == 8'h01) & irq_en_q;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  miw_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_req && mem_we && st_q == S_MIW && |mem_wdata[4:0]) |-> mem_wdata[`MIW_FAULT])
    else $error("info word cause without fault bit");
  tt_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_req && st_q == S_TT) |-> mem_addr == ptr_q + 16'h0001)
    else $error("time tag not next to info word");
  rd_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_req && !mem_we) |-> mem_addr == ptr_q + 16'h0002 + {10'h000, cnt_q})
    else $error("transmit read not two past pointer");
  sync_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_mc && code == `MC_SYNC) |=> timer_q == 16'h0000)
    else $error("timer not cleared by sync");
  tf_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tf_inhibit_q && $past(cmd_valid) && !$past(hold_status)) |-> !status_word[`ST_TFLAG])
    else $error("terminal flag while inhibited");
  last_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd_valid && last_mc) |=> $stable(last_cmd_q))
    else $error("last command code was stored");
  srq_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_mc && code == `MC_VECTOR && !wr_hit) |=> !srq_q[`SRQ_BIT])
    else $error("service request not cleared");
  depth_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    depth_zero_irq |-> ($past(depth_q) == 8'h01 && $past(irq_en_q) && desc_new_depth == 8'h00))
    else $error("depth irq without 1 to 0 step");
  tag_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == S_IDLE && cmd_valid) |=> tag_q == $past(timer_q))
    else $error("time tag not captured at command");

endmodule // rt_msg_buffer

// [test/mem_model.sv]
// shared memory model answering the block's memory port
module mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // memory port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [256];
  logic        slow_q;
  logic        wait_q;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h5A00 | 16'(i);
    end
  end

  // alternate prompt and one-wait answers; read data scrambled once the ack has passed
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      slow_q <= 1'b0;
      wait_q <= 1'b0;
      mem_rdata <= 16'hFFFF;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && slow_q && !wait_q) begin
      wait_q <= 1'b1;
    end else if (mem_req) begin
      mem_ack <= 1'b1;
      wait_q <= 1'b0;
      slow_q <= ~slow_q;
      mem_rdata <= mem[mem_addr[7:0]];
      if (mem_we) begin
        mem[mem_addr[7:0]] <= mem_wdata;
      end
    end
  end
endmodule // mem_model

// [test/tb.sv]
// self-checking bench for the terminal message buffer block
`include "rt_msg_defines.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] c; int nw; logic a, t, pe; logic [4:0] err;} row_t;
  logic        clk, rst_n, hsel, hwrite, hresp, hreadyout, cmd_valid, cmd_bus_a, cmd_bcast;
  logic        cmd_t2t, data_valid, data_parity_err, data_code_err, msg_end, tx_req;
  logic        tf_request, desc_irq_en, mem_req, mem_we, mem_ack, tx_valid, core_reset;
  logic        desc_upd, depth_zero_irq, irq_q, cr_q;
  logic [1:0]  htrans, bus_disable;
  logic [2:0]  hsize;
  logic [7:0]  haddr, desc_depth, desc_new_depth, dep_q;
  logic [15:0] cmd_word, data_word, desc_ptr, mem_addr, mem_wdata, mem_rdata, tx_word;
  logic [15:0] status_word, desc_new_ptr, ptr_q, txw_q, p, e;
  logic [31:0] hwdata, hrdata, rd;
  int          bad_count, total_checks, n;
  row_t        rows [5];

  rt_msg_buffer rt_msg_buffer_inst (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cmd_valid, .cmd_word,
    .cmd_bus_a, .cmd_bcast, .cmd_t2t, .data_valid, .data_word, .data_parity_err,
    .data_code_err, .msg_end, .tx_req, .tf_request, .desc_ptr, .desc_depth, .desc_irq_en,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .tx_valid, .tx_word,
    .status_word, .bus_disable, .core_reset, .desc_upd, .desc_new_ptr, .desc_new_depth,
    .depth_zero_irq);
  mem_model mem_model_inst (.clk, .rst_n, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata);

  always #25 clk = ~clk;
  // the reset pulse lasts one cycle, so keep a sticky copy
  always @(negedge clk) cr_q <= cr_q | core_reset;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // one whole message: command, nw data words, nt transmit requests, end
  task automatic msg(input logic [15:0] c, input int nw, nt, input logic a, t, pe);
    cmd_word <= c;
    cmd_bus_a <= a;
    cmd_t2t <= t;
    desc_ptr <= p;
    cmd_valid <= 1'b1;
    @(posedge clk) cmd_valid <= 1'b0;
    for (int i = 0; i < nw; i++) begin
      data_word <= 16'hD000 + 16'(i);
      data_parity_err <= pe;
      data_valid <= 1'b1;
      @(posedge clk) data_valid <= 1'b0;
      // a transmit command drops its data word, so no write to wait for
      if (!c[10]) begin
        do @(negedge clk); while (mem_ack !== 1'b1);
      end
      @(posedge clk);
    end
    for (int i = 0; i < nt; i++) begin
      tx_req <= 1'b1;
      @(posedge clk) tx_req <= 1'b0;
      n = 0;
      do begin @(negedge clk); n++; end while (tx_valid !== 1'b1 && n < 50);
      txw_q = tx_word;
      @(posedge clk);
    end
    msg_end <= 1'b1;
    @(posedge clk) msg_end <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (desc_upd !== 1'b1 && n < 200);
    check(32'(n < 200), 32'h1);
    ptr_q = desc_new_ptr;
    dep_q = desc_new_depth;
    irq_q = depth_zero_irq;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {clk, rst_n, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {cmd_valid, cmd_word, cmd_bus_a, cmd_bcast, cmd_t2t, data_valid, data_word} = '0;
    {data_parity_err, data_code_err, msg_end, tx_req, desc_ptr, p, cr_q} = '0;
    tf_request = 1'b1;
    desc_irq_en = 1'b1;
    desc_depth = 8'h02;
    rows = '{'{16'h1822, 2, 1, 0, 0, 5'h00}, '{16'h1823, 2, 0, 0, 0, 5'h08},
             '{16'h1841, 1, 0, 1, 1, 5'h02}, '{16'h1C21, 1, 0, 0, 0, 5'h04},
             '{16'h1C02, 0, 0, 0, 0, 5'h10}};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(status_word, 32'h0);
    check({hresp, hreadyout}, 32'h1);
    check(bus_disable, 32'h0);
    ahb(1'b0, `OFS_LAST_CMD, 32'h0);
    check(rd, 32'h0);
    ahb(1'b0, 8'h3C, 32'h0);
    check(rd, 32'h0);
    ahb(1'b1, `OFS_CTRL, 32'h5);
    ahb(1'b1, 8'h58, 32'h4);  // transmit status mode code made illegal
    ahb(1'b1, `OFS_BIT_WORD, 32'hA5C3);
    for (int i = 0; i < 5; i++) begin
      p = 16'(i * 32);
      msg(rows[i].c, rows[i].nw, 0, rows[i].a, rows[i].t, rows[i].pe);
      e = {rows[i].c[4:0], 1'b0, rows[i].a, rows[i].t & ~rows[i].c[10], |rows[i].err, 2'b00,
           rows[i].err};
      check(mem_model_inst.mem[p[7:0]], e);
      check(ptr_q, (rows[i].err == 0) ? p + 16'd2 + 16'(rows[i].nw) : p);
      check(dep_q, (rows[i].err == 0) ? 32'h1 : 32'h2);
    end
    check(status_word[`ST_ERROR], 32'h1);
    // data words are only trusted from the clean first row
    check(mem_model_inst.mem[3], 16'hD001);
    desc_depth <= 8'h01;
    p = 16'h00A0;
    msg(16'h1821, 1, 0, 1'b1, 1'b0, 1'b0);
    check({irq_q, dep_q, ptr_q}, {1'b1, 8'h00, 16'h00A3});
    p = 16'h00C0;
    msg(16'h1C21, 0, 1, 1'b1, 1'b0, 1'b0);
    check(txw_q, 16'h5AC2);
    msg(16'h1C13, 0, 1, 1'b1, 1'b0, 1'b0);
    check(txw_q, 16'hA5C3);
    msg(16'h1C12, 0, 1, 1'b1, 1'b0, 1'b0);
    check(txw_q, 16'h1C13);
    ahb(1'b0, `OFS_LAST_CMD, 32'h0);
    check(rd, 32'h1C13);
    msg(16'h1C00, 0, 0, 1'b1, 1'b0, 1'b0);
    check(status_word[`ST_DBA], 32'h1);
    msg(16'h1811, 1, 0, 1'b1, 1'b0, 1'b0);
    ahb(1'b0, `OFS_TIMER, 32'h0);
    check(32'(rd[15:0] - 16'hD000 < 16'h2), 32'h1);
    msg(16'h1C01, 0, 0, 1'b1, 1'b0, 1'b0);
    p = 16'h00E0;
    msg(16'h1821, 1, 0, 1'b1, 1'b0, 1'b0);
    check(32'(mem_model_inst.mem[8'hE1] < 16'h2), 32'h1);
    msg(16'h1C04, 0, 0, 1'b1, 1'b0, 1'b0);
    check(bus_disable, 32'h2);
    msg(16'h1C08, 0, 0, 1'b1, 1'b0, 1'b0);
    check(bus_disable, 32'h0);
    check(cr_q, 32'h1);
    msg(16'h1C06, 0, 0, 1'b1, 1'b0, 1'b0);
    check(status_word[`ST_TFLAG], 32'h0);
    msg(16'h1C07, 0, 0, 1'b1, 1'b0, 1'b0);
    check(status_word[`ST_TFLAG], 32'h1);
    ahb(1'b1, `OFS_SRQ, 32'h100);
    msg(16'h1C10, 0, 1, 1'b1, 1'b0, 1'b0);
    check(status_word[`ST_SRQ], 32'h1);
    ahb(1'b0, `OFS_SRQ, 32'h0);
    check(rd, 32'h0);
    results();
  end

  // about thirty times the length of the whole sequence
  initial begin
    #500_000;
    bad_count++;
    results();
  end
endmodule // tb
